// *** common/ipl_params.svh ***
//==========================================================================
// Purpose: Offsets, field positions, masks and reset values of the
//          priority level block
// Assumes: Register index times four is the byte address
// Notes:   Definitions only
//==========================================================================
`ifndef IPL_PARAMS_SVH
`define IPL_PARAMS_SVH

//==========================================================================
// Register indices (byte address is index times four)
//==========================================================================
`define IPL_IDX_SYS 6'h02
`define IPL_IDX_CAN 6'h03
`define IPL_IDX_SPI 6'h04
`define IPL_IDX_SER 6'h05
`define IPL_IDX_STATUS 6'h10
`define IPL_IDX_MASK 6'h11

//==========================================================================
// Writable bit masks; reserved bits are zero here
//==========================================================================
`define IPL_WMASK_SYS 16'h3FC3
`define IPL_WMASK_CAN 16'h03FC
`define IPL_WMASK_SPI 16'hFC3F
`define IPL_WMASK_SER 16'h0F3F
`define IPL_WMASK_EVT 20'hFFFFF

//==========================================================================
// Reset values
//==========================================================================
`define IPL_RST_PRIO 16'h0000
`define IPL_RST_EVT 20'h00000
`define IPL_RST_RDATA 32'h00000000

//==========================================================================
// Field low bit positions
//==========================================================================
`define IPL_POS_FLASH_CMD_DONE 12
`define IPL_POS_FLASH_FAULT 10
`define IPL_POS_PLL_UNLOCK 8
`define IPL_POS_LOW_VOLTAGE 6
`define IPL_POS_EXT_REQ_A 0
`define IPL_POS_CAN_MSGBUFFER 8
`define IPL_POS_CAN_WAKEUP 6
`define IPL_POS_CAN_FAULT 4
`define IPL_POS_CAN_BUSOFF 2
`define IPL_POS_SPI_FIRST_RXFULL 14
`define IPL_POS_SPI_SECOND_TXEMPTY 12
`define IPL_POS_SPI_SECOND_RXFULL 10
`define IPL_POS_PORT_A 4
`define IPL_POS_PORT_B 2
`define IPL_POS_PORT_C 0
`define IPL_POS_SER_RXFULL 10
`define IPL_POS_SER_RXERR 8
`define IPL_POS_SER_TXIDLE 4
`define IPL_POS_SER_TXEMPTY 2
`define IPL_POS_SPI_FIRST_TXEMPTY 0

`endif

// *** common/ipl_pkg.sv ***
//==========================================================================
// Purpose: Types shared by the priority level block
// Assumes: Twenty sources, 2-bit level fields
// Notes:   Constants live in ipl_params.svh
//==========================================================================
package ipl_pkg;

   // Source priority field and decoded level
   typedef logic [1:0] ipl_field_type;

   // Register selected by a bus address
   typedef enum logic [2:0] {
      IPL_REG_NONE,
      IPL_REG_SYS,
      IPL_REG_CAN,
      IPL_REG_SPI,
      IPL_REG_SER,
      IPL_REG_STATUS,
      IPL_REG_MASK
   } ipl_reg_type;

   // Whole state of the top module
   typedef struct packed {
      logic [15:0] system_event_priority;
      logic [15:0] can_event_priority;
      logic [15:0] spi_gpio_priority;
      logic [15:0] serial_port_priority;
      logic [19:0] status;
      logic [19:0] mask;
      logic waitreq;
      logic [31:0] rdata;
      logic irq;
      logic core_req;
      logic [1:0] core_level;
      logic [4:0] core_src;
   } ipl_state_type;

endpackage

// *** logic/ipl_field_map.sv ***
//==========================================================================
// Purpose: Slice the four priority registers into twenty source fields
// Assumes: Source order fixed, index 0 has the highest tie priority
// Notes:   Purely combinational
//==========================================================================
`timescale 1ns/100ps
`default_nettype none
`include "ipl_params.svh"

module ipl_field_map (
   input wire logic [15:0] system_event_priority,
   input wire logic [15:0] can_event_priority,
   input wire logic [15:0] spi_gpio_priority,
   input wire logic [15:0] serial_port_priority,
   output logic [19:0][1:0] fields
);

   //=======================================================================
   // Field slicing
   //=======================================================================
   // System events: flash, PLL, low voltage, external request A
   assign fields[0] = system_event_priority[`IPL_POS_FLASH_CMD_DONE +: 2];
   assign fields[1] = system_event_priority[`IPL_POS_FLASH_FAULT +: 2];
   assign fields[2] = system_event_priority[`IPL_POS_PLL_UNLOCK +: 2];
   assign fields[3] = system_event_priority[`IPL_POS_LOW_VOLTAGE +: 2];
   assign fields[4] = system_event_priority[`IPL_POS_EXT_REQ_A +: 2];
   // CAN events
   assign fields[5] = can_event_priority[`IPL_POS_CAN_MSGBUFFER +: 2];
   assign fields[6] = can_event_priority[`IPL_POS_CAN_WAKEUP +: 2];
   assign fields[7] = can_event_priority[`IPL_POS_CAN_FAULT +: 2];
   assign fields[8] = can_event_priority[`IPL_POS_CAN_BUSOFF +: 2];
   // SPI and GPIO ports
   assign fields[9] = spi_gpio_priority[`IPL_POS_SPI_FIRST_RXFULL +: 2];
   assign fields[10] = spi_gpio_priority[`IPL_POS_SPI_SECOND_TXEMPTY +: 2];
   assign fields[11] = spi_gpio_priority[`IPL_POS_SPI_SECOND_RXFULL +: 2];
   assign fields[12] = spi_gpio_priority[`IPL_POS_PORT_A +: 2];
   assign fields[13] = spi_gpio_priority[`IPL_POS_PORT_B +: 2];
   assign fields[14] = spi_gpio_priority[`IPL_POS_PORT_C +: 2];
   // Second serial port and first SPI transmit
   assign fields[15] = serial_port_priority[`IPL_POS_SER_RXFULL +: 2];
   assign fields[16] = serial_port_priority[`IPL_POS_SER_RXERR +: 2];
   assign fields[17] = serial_port_priority[`IPL_POS_SER_TXIDLE +: 2];
   assign fields[18] = serial_port_priority[`IPL_POS_SER_TXEMPTY +: 2];
   assign fields[19] = serial_port_priority[`IPL_POS_SPI_FIRST_TXEMPTY +: 2];

endmodule
`default_nettype wire

// *** logic/ipl_arbiter.sv ***
//==========================================================================
// Purpose: Pick the highest level pending source among enabled ones
// Assumes: Field 00 disables, 01..11 map to levels 0..2
// Notes:   Ties go to the lowest source index
//==========================================================================
`timescale 1ns/100ps
`default_nettype none

module ipl_arbiter (
   input wire logic [19:0] src_req,
   input wire logic [19:0][1:0] fields,
   output logic any,
   output logic [1:0] level,
   output logic [4:0] src
);

   //=======================================================================
   // Field decode
   //=======================================================================
   // Level is field minus one, so no nonzero field can exceed level 2
   function automatic logic [1:0] field_level(input logic [1:0] f);
      return f - 2'h1;
   endfunction

   //=======================================================================
   // Selection
   //=======================================================================
   // Strict greater-than keeps the earlier index on a tie
   always_comb begin
      any = 1'b0;
      level = 2'h0;
      src = 5'h00;
      for (int i = 0; i < 20; i++) begin
         if (src_req[i] && fields[i] != 2'h0) begin
            if (!any || field_level(fields[i]) > level) begin
               any = 1'b1;
               level = field_level(fields[i]);
               src = 5'(i);
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** logic/ipl_regs.sv ***
//==========================================================================
// Purpose: Priority level registers for twenty interrupt sources, with
//          Avalon-MM access, event status and one forwarded core request
// Assumes: Source requests come from logic on the same clock
// Notes:   Every access answers one cycle after it is seen
//==========================================================================
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ipl_params.svh"

module ipl_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [19:0] src_req,
   output logic core_req,
   output logic [1:0] core_level,
   output logic [4:0] core_src,
   output logic irq
);

   //=======================================================================
   // State
   //=======================================================================
   ipl_pkg::ipl_state_type st_r;
   ipl_pkg::ipl_state_type st_nxt;
   logic [19:0][1:0] fields;
   logic arb_any;
   logic [1:0] arb_level;
   logic [4:0] arb_src;
   logic [19:0] enabled;
   logic [19:0] status_set;
   logic [31:0] lane_mask;
   logic ack_write;
   ipl_pkg::ipl_reg_type wsel;

   //=======================================================================
   // Helpers
   //=======================================================================
   // Address decode, shared by read and write paths
   function automatic ipl_pkg::ipl_reg_type reg_sel(input logic [7:0] a);
      if (a[1:0] != 2'h0) begin
         return ipl_pkg::IPL_REG_NONE;
      end
      case (a[7:2])
         `IPL_IDX_SYS: return ipl_pkg::IPL_REG_SYS;
         `IPL_IDX_CAN: return ipl_pkg::IPL_REG_CAN;
         `IPL_IDX_SPI: return ipl_pkg::IPL_REG_SPI;
         `IPL_IDX_SER: return ipl_pkg::IPL_REG_SER;
         `IPL_IDX_STATUS: return ipl_pkg::IPL_REG_STATUS;
         `IPL_IDX_MASK: return ipl_pkg::IPL_REG_MASK;
         default: return ipl_pkg::IPL_REG_NONE;
      endcase
   endfunction

   // Merge a write into a 16-bit register through its writable mask
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [15:0] lanes,
                                           input logic [15:0] wmask);
      logic [15:0] m;
      m = lanes & wmask;
      return (old & ~m) | (wd & m);
   endfunction

   //=======================================================================
   // Submodules
   //=======================================================================
   ipl_field_map u_map (
      .system_event_priority(st_r.system_event_priority),
      .can_event_priority(st_r.can_event_priority),
      .spi_gpio_priority(st_r.spi_gpio_priority),
      .serial_port_priority(st_r.serial_port_priority),
      .fields(fields)
   );

   ipl_arbiter u_arb (
      .src_req(src_req),
      .fields(fields),
      .any(arb_any),
      .level(arb_level),
      .src(arb_src)
   );

   //=======================================================================
   // Enables and events
   //=======================================================================
   // A source counts as enabled only with a nonzero field
   always_comb begin
      for (int i = 0; i < 20; i++) begin
         enabled[i] = fields[i] != 2'h0;
      end
   end

   assign status_set = src_req & enabled;

   // Byte enables widened to bit lanes
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         lane_mask[b*8 +: 8] = {8{byteenable[b]}};
      end
   end

   // A write commits only at the edge where waitrequest is seen low
   assign ack_write = write && !st_r.waitreq;
   assign wsel = reg_sel(address);

   //=======================================================================
   // Next state
   //=======================================================================
   always_comb begin
      st_nxt = st_r;
      // Bus handshake: one wait cycle, then one ack cycle
      st_nxt.waitreq = !(st_r.waitreq && (read || write));
      if (st_r.waitreq && read) begin
         case (wsel)
            ipl_pkg::IPL_REG_SYS:
               st_nxt.rdata = {16'h0000, st_r.system_event_priority};
            ipl_pkg::IPL_REG_CAN:
               st_nxt.rdata = {16'h0000, st_r.can_event_priority};
            ipl_pkg::IPL_REG_SPI:
               st_nxt.rdata = {16'h0000, st_r.spi_gpio_priority};
            ipl_pkg::IPL_REG_SER:
               st_nxt.rdata = {16'h0000, st_r.serial_port_priority};
            ipl_pkg::IPL_REG_STATUS:
               st_nxt.rdata = {12'h000, st_r.status};
            ipl_pkg::IPL_REG_MASK:
               st_nxt.rdata = {12'h000, st_r.mask};
            default:
               st_nxt.rdata = `IPL_RST_RDATA;
         endcase
      end
      if (ack_write) begin
         case (wsel)
            ipl_pkg::IPL_REG_SYS:
               st_nxt.system_event_priority = merge16(
                  st_r.system_event_priority, writedata[15:0],
                  lane_mask[15:0], `IPL_WMASK_SYS);
            ipl_pkg::IPL_REG_CAN:
               st_nxt.can_event_priority = merge16(
                  st_r.can_event_priority, writedata[15:0],
                  lane_mask[15:0], `IPL_WMASK_CAN);
            ipl_pkg::IPL_REG_SPI:
               st_nxt.spi_gpio_priority = merge16(
                  st_r.spi_gpio_priority, writedata[15:0],
                  lane_mask[15:0], `IPL_WMASK_SPI);
            ipl_pkg::IPL_REG_SER:
               st_nxt.serial_port_priority = merge16(
                  st_r.serial_port_priority, writedata[15:0],
                  lane_mask[15:0], `IPL_WMASK_SER);
            ipl_pkg::IPL_REG_MASK:
               st_nxt.mask = (st_r.mask & ~lane_mask[19:0])
                  | (writedata[19:0] & lane_mask[19:0]);
            default: begin
            end
         endcase
      end
      // Set wins over a same-cycle write-one clear
      if (ack_write && wsel == ipl_pkg::IPL_REG_STATUS) begin
         st_nxt.status = (st_r.status & ~(writedata[19:0] & lane_mask[19:0]))
            | status_set;
      end else begin
         st_nxt.status = st_r.status | status_set;
      end
      st_nxt.irq = |(st_r.status & st_r.mask);
      st_nxt.core_req = arb_any;
      st_nxt.core_level = arb_any ? arb_level : 2'h0;
      st_nxt.core_src = arb_any ? arb_src : 5'h00;
      if (!rst_n) begin
         st_nxt = '0;
         st_nxt.system_event_priority = `IPL_RST_PRIO;
         st_nxt.can_event_priority = `IPL_RST_PRIO;
         st_nxt.spi_gpio_priority = `IPL_RST_PRIO;
         st_nxt.serial_port_priority = `IPL_RST_PRIO;
         st_nxt.status = `IPL_RST_EVT;
         st_nxt.mask = `IPL_RST_EVT;
         st_nxt.rdata = `IPL_RST_RDATA;
         st_nxt.waitreq = 1'b1;
      end
   end

   // Reset folded into next state, so one plain register stage
   always_ff @(posedge clock) begin
      st_r <= st_nxt;
   end

   //=======================================================================
   // Outputs, all straight from flops
   //=======================================================================
   assign readdata = st_r.rdata;
   assign waitrequest = st_r.waitreq;
   assign core_req = st_r.core_req;
   assign core_level = st_r.core_level;
   assign core_src = st_r.core_src;
   assign irq = st_r.irq;

   //=======================================================================
   // Assertions
   //=======================================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic [1:0] sel_field;
   assign sel_field = fields[arb_src];

   sequence write_ack_s(logic [5:0] idx);
      write && !waitrequest && address == {idx, 2'h0}
         && byteenable[1:0] == 2'h3;
   endsequence

   sequence read_seen_s(logic [5:0] idx);
      read && waitrequest && address == {idx, 2'h0};
   endsequence

   // Reset leaves every field clear and no request out
   reset_clears_a:
   assert property ($past(!rst_n) |-> st_r.system_event_priority == 16'h0
      && st_r.can_event_priority == 16'h0 && st_r.spi_gpio_priority == 16'h0
      && st_r.serial_port_priority == 16'h0 && !core_req)
   else $error("priority fields not clear after reset");

   // Reserved positions never hold a one
   reserved_zero_a:
   assert property ((st_r.system_event_priority & ~`IPL_WMASK_SYS) == 16'h0
      && (st_r.can_event_priority & ~`IPL_WMASK_CAN) == 16'h0
      && (st_r.spi_gpio_priority & ~`IPL_WMASK_SPI) == 16'h0
      && (st_r.serial_port_priority & ~`IPL_WMASK_SER) == 16'h0)
   else $error("reserved bit set in a priority register");

   sys_layout_a:
   assert property (write_ack_s(`IPL_IDX_SYS) |=>
      st_r.system_event_priority == ($past(writedata[15:0]) & 16'h3FC3))
   else $error("system register write landed wrong");

   can_layout_a:
   assert property (write_ack_s(`IPL_IDX_CAN) |=>
      st_r.can_event_priority == ($past(writedata[15:0]) & 16'h03FC))
   else $error("CAN register write landed wrong");

   spi_layout_a:
   assert property (write_ack_s(`IPL_IDX_SPI) |=>
      st_r.spi_gpio_priority == ($past(writedata[15:0]) & 16'hFC3F))
   else $error("SPI/GPIO register write landed wrong");

   ser_layout_a:
   assert property (write_ack_s(`IPL_IDX_SER) |=>
      st_r.serial_port_priority == ($past(writedata[15:0]) & 16'h0F3F))
   else $error("serial register write landed wrong");

   // Forwarded level is the chosen field minus one
   level_tag_a:
   assert property (arb_any |=> core_req
      && core_level == $past(sel_field) - 2'h1)
   else $error("forwarded level does not match field");

   level_cap_a:
   assert property (core_req |-> core_level != 2'h3)
   else $error("level above 2 forwarded");

   disabled_blocked_a:
   assert property ((src_req & enabled) == 20'h0 |=> !core_req)
   else $error("disabled source forwarded");

   // Exactly one wait cycle, then a one-cycle answer
   bus_answer_a:
   assert property ((read || write) && waitrequest |=> !waitrequest
      ##1 waitrequest)
   else $error("bus answer not one cycle long");

   // Level interrupt lags the unmasked status by one cycle
   irq_follow_a:
   assert property (irq == $past(|(st_r.status & st_r.mask)))
   else $error("interrupt output does not follow status");

   // Idle bus keeps waitrequest high
   idle_wait_a:
   assert property (!(read || write) && waitrequest |=> waitrequest)
   else $error("waitrequest dropped with no request");

   // Status bits only drop through an accepted write-one clear
   status_sticky_a:
   assert property (!(write && !waitrequest
      && address == {`IPL_IDX_STATUS, 2'h0})
      |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
   else $error("status bit lost without a clear");

   // Reserved system bits come back as zero on the bus
   reserved_read_a:
   assert property (read_seen_s(`IPL_IDX_SYS) |=>
      readdata[31:14] == 18'h00000 && readdata[5:2] == 4'h0)
   else $error("reserved bits read back nonzero");

endmodule
`default_nettype wire

// *** tb/ipl_core_model.sv ***
//==========================================================================
// Purpose: Core side sink for the forwarded request, level and source
// Assumes: Same clock and reset as the priority block
// Notes:   Counts any taken request whose level is out of range
//==========================================================================
`timescale 1ns/100ps
`default_nettype none

module ipl_core_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic core_req,
   input wire logic [1:0] core_level,
   input wire logic [4:0] core_src,
   output logic [6:0] taken,
   output logic [7:0] bad_cnt
);
   //=======================================================================
   // Request intake
   //=======================================================================
   // level range check
   // Core latches level and source each cycle a request stands
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         taken <= 7'h00;
         bad_cnt <= 8'h00;
      end else if (core_req === 1'b1) begin
         taken <= {core_level, core_src};
         // A fourth level has no meaning to the core
         if (core_level === 2'h3) begin
            bad_cnt <= bad_cnt + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/ipl_regs_tb.sv ***
//==========================================================================
// Purpose: Self-checking bench for the priority level registers
// Assumes: One wait cycle per bus access, levels lag sources by one cycle
// Notes:   Byte lanes stay all on; lane gating is not exercised
//==========================================================================
`timescale 1ns/100ps
`default_nettype none
`include "ipl_params.svh"

module ipl_regs_tb;
   //=======================================================================
   // Signals
   //=======================================================================
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic [19:0] src_req = 20'h00000;
   logic core_req;
   logic [1:0] core_level;
   logic [4:0] core_src;
   logic irq;
   logic [6:0] taken;
   logic [7:0] bad_cnt;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   localparam logic [7:0] A_STS = {`IPL_IDX_STATUS, 2'h0};
   localparam logic [7:0] A_MSK = {`IPL_IDX_MASK, 2'h0};
   logic [7:0] reg_a [4] = '{{`IPL_IDX_SYS, 2'h0}, {`IPL_IDX_CAN, 2'h0},
      {`IPL_IDX_SPI, 2'h0}, {`IPL_IDX_SER, 2'h0}};
   // Field low bit and register of every source, in source index order
   int pos_t [20] = '{`IPL_POS_FLASH_CMD_DONE, `IPL_POS_FLASH_FAULT,
      `IPL_POS_PLL_UNLOCK, `IPL_POS_LOW_VOLTAGE, `IPL_POS_EXT_REQ_A,
      `IPL_POS_CAN_MSGBUFFER, `IPL_POS_CAN_WAKEUP, `IPL_POS_CAN_FAULT,
      `IPL_POS_CAN_BUSOFF, `IPL_POS_SPI_FIRST_RXFULL,
      `IPL_POS_SPI_SECOND_TXEMPTY, `IPL_POS_SPI_SECOND_RXFULL,
      `IPL_POS_PORT_A, `IPL_POS_PORT_B, `IPL_POS_PORT_C,
      `IPL_POS_SER_RXFULL, `IPL_POS_SER_RXERR, `IPL_POS_SER_TXIDLE,
      `IPL_POS_SER_TXEMPTY, `IPL_POS_SPI_FIRST_TXEMPTY};
   int reg_t [20] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2,
      3, 3, 3, 3, 3};
   logic [15:0] reg_m [4] = '{`IPL_WMASK_SYS, `IPL_WMASK_CAN,
      `IPL_WMASK_SPI, `IPL_WMASK_SER};
   // Expected {req, level, source} for ext A field 0..3 against flash 01
   logic [7:0] dec_e [4] = '{8'h80, 8'h80, 8'hA4, 8'hC4};

   // 200 MHz clock
   always #2.5 clock = ~clock;

   ipl_regs i_dut (
      .clock(clock),
      .rst_n(rst_n),
      .address(address),
      .read(read),
      .write(write),
      .byteenable(4'hF),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .src_req(src_req),
      .core_req(core_req),
      .core_level(core_level),
      .core_src(core_src),
      .irq(irq)
   );

   ipl_core_model i_core (
      .clock(clock),
      .rst_n(rst_n),
      .core_req(core_req),
      .core_level(core_level),
      .core_src(core_src),
      .taken(taken),
      .bad_cnt(bad_cnt)
   );

   //=======================================================================
   // Shared tasks
   //=======================================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(q, e);
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   //=======================================================================
   // Scenarios
   //=======================================================================
   task automatic t_reset_values();
      for (int i = 0; i < 4; i++) begin
         rd(reg_a[i], 32'h00000000);
      end
      rd(A_STS, 32'h00000000);
   endtask

   // All ones into each register, only field bits may stick
   task automatic t_reserved();
      for (int i = 0; i < 4; i++) begin
         wr(reg_a[i], 32'hFFFFFFFF);
         rd(reg_a[i], {16'h0000, reg_m[i]});
         wr(reg_a[i], 32'h00000000);
         rd(reg_a[i], 32'h00000000);
      end
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h00000000);
      rd(8'h09, 32'h00000000);
   endtask

   // Every source requests while every field is 00
   task automatic t_disabled();
      @(posedge clock);
      src_req <= 20'hFFFFF;
      repeat (3) @(posedge clock);
      chk({31'h00000000, core_req}, 32'h00000000);
      src_req <= 20'h00000;
      rd(A_STS, 32'h00000000);
   endtask

   // Ext A swept through all codes, flash fixed at level 0
   task automatic t_decode();
      for (int v = 0; v < 4; v++) begin
         wr(reg_a[0], 32'h00001000 | v);
         src_req <= 20'h00011;
         repeat (2) @(posedge clock);
         chk({core_req, core_level, core_src}, dec_e[v]);
         @(posedge clock);
         chk({1'b1, taken}, dec_e[v]);
         src_req <= 20'h00000;
      end
   endtask

   // Sticky status, mask, level irq, write one to clear
   task automatic t_irq();
      rd(A_STS, 32'h00000011);
      chk({31'h00000000, irq}, 32'h00000000);
      wr(A_MSK, 32'h00000010);
      rd(A_MSK, 32'h00000010);
      chk({31'h00000000, irq}, 32'h00000001);
      wr(A_STS, 32'h00000010);
      repeat (2) @(posedge clock);
      chk({31'h00000000, irq}, 32'h00000000);
      rd(A_STS, 32'h00000001);
   endtask

   // Each source alone at level 2 must come out under its own index
   task automatic t_route();
      for (int s = 0; s < 20; s++) begin
         wr(reg_a[reg_t[s]], 32'h00000003 << pos_t[s]);
         src_req <= 20'h00001 << s;
         repeat (2) @(posedge clock);
         chk({core_req, core_level}, 32'h00000006);
         chk(core_src, s);
         src_req <= 20'h00000;
         wr(reg_a[reg_t[s]], 32'h00000000);
      end
   endtask

   //=======================================================================
   // Main sequence and hang guard
   //=======================================================================
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      t_reset_values();
      t_reserved();
      t_disabled();
      t_decode();
      t_irq();
      t_route();
      chk({24'h000000, bad_cnt}, 32'h00000000);
      wrap_up();
   end

   // Whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         wrap_up();
      end
   end
endmodule
`default_nettype wire
